// ===== rtl/scb_defs.svh
/*
  Word indices, field positions, reset values and the lock pattern of the
  calibration word bank.
  Assumes inclusion by bare name from every file that needs these values.
*/
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH

////////////////////////////////////////////////////////////////////////////
// Word indices
`define SCB_IDX_SIGN      4'h1
`define SCB_IDX_CFG       4'h2
`define SCB_IDX_BOFF      4'h3
`define SCB_IDX_BGAIN     4'h4
`define SCB_IDX_TCG       4'h5
`define SCB_IDX_TCO       4'h6
`define SCB_IDX_SO_TCO    4'h7
`define SCB_IDX_SO_TCG    4'h8
`define SCB_IDX_SO_BR     4'h9
`define SCB_IDX_TOFF      4'hA
`define SCB_IDX_TGAIN     4'hB
`define SCB_IDX_SO_T      4'hC
`define SCB_IDX_TSETL     4'hD
`define SCB_IDX_CUST1     4'hE
`define SCB_IDX_FIRST     4'h1
`define SCB_IDX_LAST      4'hE

////////////////////////////////////////////////////////////////////////////
// Config word fields
`define SCB_CFG_SPI_POL   0
`define SCB_CFG_DG_CONN   1
`define SCB_CFG_DG_SHORT  2
`define SCB_CFG_ADDR_LSB  3
`define SCB_CFG_ADDR_MSB  9
`define SCB_CFG_ALK_LSB   10
`define SCB_CFG_ALK_MSB   12
`define SCB_CFG_MLK_LSB   13
`define SCB_CFG_MLK_MSB   15
`define SCB_LOCK_PATTERN  3'h3

////////////////////////////////////////////////////////////////////////////
// Sign word fields and gain word x8 bit
`define SCB_SW_CURVE      9
`define SCB_SW_TC_OFF     10
`define SCB_SW_TC_GAIN    11
`define SCB_SW_SO_BR      12
`define SCB_SW_SO_TCO     13
`define SCB_SW_SO_TCG     14
`define SCB_SW_SO_T       15
`define SCB_GAIN_X8_BIT   15

////////////////////////////////////////////////////////////////////////////
// Reset values
`define SCB_RST_SIGN      16'h0049
`define SCB_RST_CFG       16'h0140
`define SCB_RST_ZERO      16'h0000
`define SCB_RST_GAIN      16'h2000
`define SCB_RST_SLAVE     7'h28

`endif

// ===== rtl/scb_pkg.sv
/*
  Types and the shared default-word decode of the calibration word bank.
  Assumes scb_defs.svh is on the include path.
*/
`include "scb_defs.svh"

package scb_pkg;

  typedef logic [15:0] scb_word_t;
  typedef logic [3:0]  scb_idx_t;

  typedef enum logic [4:0] {
    SCB_ST_LOAD  = 5'h01,
    SCB_ST_CHECK = 5'h02,
    SCB_ST_RUN   = 5'h04,
    SCB_ST_SIGN  = 5'h08,
    SCB_ST_STORE = 5'h10
  } scb_state_t;

  // Factory default of a word
  function automatic scb_word_t scb_default_word(input scb_idx_t idx, input logic [7:0] ss);
    case (idx)
      `SCB_IDX_SIGN:  scb_default_word = `SCB_RST_SIGN;
      `SCB_IDX_CFG:   scb_default_word = `SCB_RST_CFG;
      `SCB_IDX_BGAIN: scb_default_word = `SCB_RST_GAIN;
      `SCB_IDX_TGAIN: scb_default_word = `SCB_RST_GAIN;
      `SCB_IDX_CUST1: scb_default_word = {8'h00, ss};
      default:        scb_default_word = `SCB_RST_ZERO;
    endcase
  endfunction : scb_default_word

endpackage : scb_pkg

// ===== rtl/scb_nvm_store.sv
/*
  Nonvolatile word array plus signature word, with programming gated by the
  charge pump enable.
  Assumes contents survive rst_i; they are undefined until a factory load.
*/
`timescale 1ns/1ns
`include "scb_defs.svh"

module scb_nvm_store #(
  parameter logic [7:0] WAFER_Y = 8'h00
) (
  // Clock
  input  wire logic              clk_sys_i,
  input  wire logic              ce_i,
  // Control
  input  wire logic              pump_en_i,
  input  wire logic              factory_i,
  // Word write
  input  wire logic              wr_en_i,
  input  wire scb_pkg::scb_idx_t wr_idx_i,
  input  wire scb_pkg::scb_word_t wr_data_i,
  // Word read
  input  wire scb_pkg::scb_idx_t rd_idx_i,
  output scb_pkg::scb_word_t     rd_data_o,
  // Signature
  input  wire logic              sig_wr_i,
  input  wire scb_pkg::scb_word_t sig_data_i,
  output scb_pkg::scb_word_t     sig_o
);
  import scb_pkg::*;

  scb_word_t mem_reg [`SCB_IDX_FIRST:`SCB_IDX_LAST];
  scb_word_t mem_next [`SCB_IDX_FIRST:`SCB_IDX_LAST];
  scb_word_t sig_reg;
  scb_word_t sig_next;

  ////////////////////////////////////////////////////////////////////////
  // Programming, blocked while the pump is off
  always_comb begin
    for (int i = `SCB_IDX_FIRST; i <= `SCB_IDX_LAST; i++) begin
      mem_next[i] = mem_reg[i];
      if (pump_en_i && factory_i) begin
        mem_next[i] = scb_default_word(4'(i), WAFER_Y);
      end else if (pump_en_i && wr_en_i && wr_idx_i == 4'(i)) begin
        mem_next[i] = wr_data_i;
      end
    end
    sig_next = sig_reg;
    if (pump_en_i && sig_wr_i) begin
      sig_next = sig_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      for (int i = `SCB_IDX_FIRST; i <= `SCB_IDX_LAST; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      sig_reg <= sig_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read
  assign rd_data_o = (rd_idx_i >= `SCB_IDX_FIRST && rd_idx_i <= `SCB_IDX_LAST) ?
                     mem_reg[rd_idx_i] : `SCB_RST_ZERO;
  assign sig_o     = sig_reg;

endmodule : scb_nvm_store

// ===== rtl/scb_word_bank.sv
/*
  Calibration and configuration word bank: power-up load with signature
  check, word access port, address-match answer, serial output edge select
  and decoded coefficient outputs.
  Assumes a two-wire front end on clk_sys_i that delivers word commands and
  received slave addresses; the serial pins are asynchronous.
*/
// Function
// - Polarity bit picks serial output update edge
// - Diagnostic bits enable connection and short checks
// - Slave address defaults 28h, range 00h-7Fh
// - Address lock 011 answers programmed address only
// - Unlocked bank answers every address
// - Memory lock 011 stops all programming forever
// - Lock before signature gives permanent diagnostic
// - Word 03h signed bridge offset, reset zero
// - Word 04h 15-bit gain, 2000h is unity
// - Word 04h bit 15 scales gain by eight
// - Word 05h gain TC magnitude, sign bit
// - Word 06h offset TC magnitude, sign bit
// - Word 07h offset TC second order, sign
// - Word 08h gain TC second order, sign
// - Word 09h bridge second order, curve select
// - Word 0Ah temperature offset, factory calibrated
// - Word 0Bh temperature gain, bit 15 times eight
// - Word 0Ch temperature second order, parabolic
// - Word 0Dh raw temperature at low calibration
// - Word 0Eh customer ID part, wafer Y
// - Word 01h bits 11:10 first-order signs
// - Word 01h bits 15:12 second-order signs
// - Word 01h bit 9 curve shape
`timescale 1ns/1ns
`include "scb_defs.svh"

module scb_word_bank #(
  parameter logic [7:0] WAFER_Y = 8'h00
) (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // Word access
  input  wire logic               cmd_valid_i,
  input  wire logic               cmd_write_i,
  input  wire logic [7:0]         cmd_word_i,
  input  wire scb_pkg::scb_word_t cmd_wdata_i,
  output logic                    cmd_busy_o,
  output logic                    rsp_valid_o,
  output scb_pkg::scb_word_t      rsp_data_o,
  // Commands
  input  wire logic               enter_normal_operation_cmd_i,
  input  wire logic               factory_load_i,
  // Two-wire address match
  input  wire logic               addr_valid_i,
  input  wire logic [6:0]         addr_i,
  output logic                    addr_ack_valid_o,
  output logic                    addr_ack_o,
  // Serial output
  input  wire logic               spi_sclk_i,
  input  wire logic               spi_ss_n_i,
  input  wire scb_pkg::scb_word_t spi_data_i,
  output logic                    spi_miso_o,
  // Status and configuration
  output logic                    diag_state_o,
  output logic                    nvm_write_lock_o,
  output logic                    addr_lock_o,
  output logic                    conn_check_en_o,
  output logic                    short_check_en_o,
  output logic [6:0]              slave_addr_o,
  // Coefficients
  output logic signed [15:0]      bridge_offset_o,
  output logic [17:0]             bridge_gain_o,
  output logic signed [16:0]      gain_tc_o,
  output logic signed [16:0]      offset_tc_o,
  output logic signed [16:0]      offset_tc_so_o,
  output logic signed [16:0]      gain_tc_so_o,
  output logic signed [16:0]      bridge_so_o,
  output logic                    curve_shape_select_o,
  output scb_pkg::scb_word_t      temp_offset_o,
  output logic [17:0]             temp_gain_o,
  output logic signed [16:0]      temp_so_o,
  output scb_pkg::scb_word_t      low_cal_raw_temperature_o,
  output scb_pkg::scb_word_t      customer_identifier_word1_o
);
  import scb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic signed [16:0] scb_signed(input scb_word_t mag, input logic neg);
    scb_signed = neg ? 17'(17'h00000 - {1'b0, mag}) : {1'b0, mag};
  endfunction : scb_signed

  function automatic logic [17:0] scb_gain(input scb_word_t w);
    scb_gain = w[`SCB_GAIN_X8_BIT] ? {w[14:0], 3'h0} : {3'h0, w[14:0]};
  endfunction : scb_gain

  function automatic scb_word_t scb_sum(input scb_word_t acc, input scb_word_t w);
    scb_sum = 16'(acc + w);
  endfunction : scb_sum

  function automatic logic scb_mapped(input logic [7:0] w);
    scb_mapped = (w >= {4'h0, `SCB_IDX_FIRST}) && (w <= {4'h0, `SCB_IDX_LAST});
  endfunction : scb_mapped

  ////////////////////////////////////////////////////////////////////////
  // State
  scb_state_t state_reg;
  scb_state_t state_next;
  scb_idx_t   idx_reg;
  scb_idx_t   idx_next;
  scb_word_t  sum_reg;
  scb_word_t  sum_next;
  logic       diag_reg;
  logic       diag_next;
  logic       busy_reg;
  logic       busy_next;
  logic       rsp_valid_reg;
  logic       rsp_valid_next;
  scb_word_t  rsp_data_reg;
  scb_word_t  rsp_data_next;
  scb_word_t  sh_reg [`SCB_IDX_FIRST:`SCB_IDX_LAST];
  scb_word_t  sh_next [`SCB_IDX_FIRST:`SCB_IDX_LAST];

  logic       st_wr_en;
  logic       st_fact;
  logic       st_sig_wr;
  scb_idx_t   st_rd_idx;
  scb_word_t  st_rd_data;
  scb_word_t  st_sig;
  logic       pump_en;
  logic       addr_locked;

  // Locks follow the loaded config copy; an unknown field reads unlocked
  always_comb begin
    case (sh_reg[`SCB_IDX_CFG][`SCB_CFG_MLK_MSB:`SCB_CFG_MLK_LSB])
      `SCB_LOCK_PATTERN: pump_en = 1'b0;
      default:           pump_en = 1'b1;
    endcase
    case (sh_reg[`SCB_IDX_CFG][`SCB_CFG_ALK_MSB:`SCB_CFG_ALK_LSB])
      `SCB_LOCK_PATTERN: addr_locked = 1'b1;
      default:           addr_locked = 1'b0;
    endcase
  end

  scb_nvm_store #(
    .WAFER_Y (WAFER_Y)
  ) u_store (
    .clk_sys_i  (clk_sys_i),
    .ce_i       (ce_i),
    .pump_en_i  (pump_en),
    .factory_i  (st_fact),
    .wr_en_i    (st_wr_en),
    .wr_idx_i   (cmd_word_i[3:0]),
    .wr_data_i  (cmd_wdata_i),
    .rd_idx_i   (st_rd_idx),
    .rd_data_o  (st_rd_data),
    .sig_wr_i   (st_sig_wr),
    .sig_data_i (sum_reg),
    .sig_o      (st_sig)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: load, check, run, sign, store
  always_comb begin
    state_next     = state_reg;
    idx_next       = idx_reg;
    sum_next       = sum_reg;
    diag_next      = diag_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next  = rsp_data_reg;
    st_wr_en       = 1'b0;
    st_fact        = 1'b0;
    st_sig_wr      = 1'b0;
    st_rd_idx      = idx_reg;
    for (int i = `SCB_IDX_FIRST; i <= `SCB_IDX_LAST; i++) begin
      sh_next[i] = sh_reg[i];
    end
    case (state_reg)
      SCB_ST_LOAD: begin
        sh_next[idx_reg] = st_rd_data;
        sum_next         = scb_sum(sum_reg, st_rd_data);
        if (idx_reg == `SCB_IDX_LAST) begin
          state_next = SCB_ST_CHECK;
        end else begin
          idx_next = 4'(idx_reg + 4'h1);
        end
      end
      SCB_ST_CHECK: begin
        diag_next  = (sum_reg != st_sig);
        state_next = SCB_ST_RUN;
      end
      SCB_ST_RUN: begin
        if (cmd_valid_i) begin
          st_rd_idx = cmd_word_i[3:0];
          if (cmd_write_i) begin
            st_wr_en = scb_mapped(cmd_word_i);
            if (scb_mapped(cmd_word_i) && pump_en &&
                cmd_word_i[3:0] != `SCB_IDX_CFG) begin
              sh_next[cmd_word_i[3:0]] = cmd_wdata_i;
            end
          end else begin
            rsp_valid_next = 1'b1;
            rsp_data_next  = scb_mapped(cmd_word_i) ? st_rd_data : `SCB_RST_ZERO;
          end
        end else if (enter_normal_operation_cmd_i) begin
          idx_next   = `SCB_IDX_FIRST;
          sum_next   = `SCB_RST_ZERO;
          state_next = SCB_ST_SIGN;
        end else if (factory_load_i && pump_en) begin
          st_fact    = 1'b1;
          idx_next   = `SCB_IDX_FIRST;
          sum_next   = `SCB_RST_ZERO;
          state_next = SCB_ST_SIGN;
        end
      end
      SCB_ST_SIGN: begin
        sum_next = scb_sum(sum_reg, st_rd_data);
        if (idx_reg == `SCB_IDX_LAST) begin
          state_next = SCB_ST_STORE;
        end else begin
          idx_next = 4'(idx_reg + 4'h1);
        end
      end
      SCB_ST_STORE: begin
        st_sig_wr  = pump_en;
        diag_next  = pump_en ? 1'b0 : diag_reg;
        state_next = SCB_ST_RUN;
      end
      default: begin
        state_next = SCB_ST_LOAD;
        idx_next   = `SCB_IDX_FIRST;
        sum_next   = `SCB_RST_ZERO;
      end
    endcase
    busy_next = (state_next != SCB_ST_RUN);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg     <= SCB_ST_LOAD;
      idx_reg       <= `SCB_IDX_FIRST;
      sum_reg       <= `SCB_RST_ZERO;
      diag_reg      <= 1'b0;
      busy_reg      <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= `SCB_RST_ZERO;
      for (int i = `SCB_IDX_FIRST; i <= `SCB_IDX_LAST; i++) begin
        sh_reg[i] <= scb_default_word(4'(i), 8'h00);
      end
    end else if (ce_i) begin
      state_reg     <= state_next;
      idx_reg       <= idx_next;
      sum_reg       <= sum_next;
      diag_reg      <= diag_next;
      busy_reg      <= busy_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
      for (int i = `SCB_IDX_FIRST; i <= `SCB_IDX_LAST; i++) begin
        sh_reg[i] <= sh_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-wire address answer
  logic ack_valid_reg;
  logic ack_valid_next;
  logic ack_reg;
  logic ack_next;

  always_comb begin
    ack_valid_next = addr_valid_i && (state_reg == SCB_ST_RUN);
    ack_next       = 1'b0;
    if (addr_valid_i && (state_reg == SCB_ST_RUN)) begin
      if (addr_locked) begin
        ack_next = (addr_i ==
                    sh_reg[`SCB_IDX_CFG][`SCB_CFG_ADDR_MSB:`SCB_CFG_ADDR_LSB]);
      end else begin
        ack_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_valid_reg <= 1'b0;
      ack_reg       <= 1'b0;
    end else if (ce_i) begin
      ack_valid_reg <= ack_valid_next;
      ack_reg       <= ack_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output shifter
  logic      sclk_s1_reg;
  logic      sclk_s2_reg;
  logic      sclk_s3_reg;
  logic      ss_s1_reg;
  logic      ss_s2_reg;
  logic      ss_s3_reg;
  scb_word_t spi_sh_reg;
  scb_word_t spi_sh_next;
  logic      miso_reg;
  logic      miso_next;
  logic      upd_edge;

  always_comb begin
    // Polarity 0 updates on falling, 1 on rising clock
    if (sh_reg[`SCB_IDX_CFG][`SCB_CFG_SPI_POL]) begin
      upd_edge = sclk_s2_reg && !sclk_s3_reg;
    end else begin
      upd_edge = !sclk_s2_reg && sclk_s3_reg;
    end
    spi_sh_next = spi_sh_reg;
    miso_next   = miso_reg;
    if (ss_s3_reg && !ss_s2_reg) begin
      spi_sh_next = spi_data_i;
      miso_next   = spi_data_i[15];
    end else if (!ss_s2_reg && upd_edge) begin
      spi_sh_next = {spi_sh_reg[14:0], 1'b0};
      miso_next   = spi_sh_reg[14];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      ss_s1_reg   <= 1'b1;
      ss_s2_reg   <= 1'b1;
      ss_s3_reg   <= 1'b1;
      spi_sh_reg  <= `SCB_RST_ZERO;
      miso_reg    <= 1'b0;
    end else if (ce_i) begin
      sclk_s1_reg <= spi_sclk_i;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      ss_s1_reg   <= spi_ss_n_i;
      ss_s2_reg   <= ss_s1_reg;
      ss_s3_reg   <= ss_s2_reg;
      spi_sh_reg  <= spi_sh_next;
      miso_reg    <= miso_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded outputs
  scb_word_t sw;
  scb_word_t cw;
  assign sw = sh_reg[`SCB_IDX_SIGN];
  assign cw = sh_reg[`SCB_IDX_CFG];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nvm_write_lock_o            <= 1'b0;
      addr_lock_o                 <= 1'b0;
      conn_check_en_o             <= 1'b0;
      short_check_en_o            <= 1'b0;
      slave_addr_o                <= `SCB_RST_SLAVE;
      bridge_offset_o             <= 16'sh0000;
      bridge_gain_o               <= 18'h02000;
      gain_tc_o                   <= 17'sh00000;
      offset_tc_o                 <= 17'sh00000;
      offset_tc_so_o              <= 17'sh00000;
      gain_tc_so_o                <= 17'sh00000;
      bridge_so_o                 <= 17'sh00000;
      curve_shape_select_o        <= 1'b0;
      temp_offset_o               <= `SCB_RST_ZERO;
      temp_gain_o                 <= 18'h02000;
      temp_so_o                   <= 17'sh00000;
      low_cal_raw_temperature_o   <= `SCB_RST_ZERO;
      customer_identifier_word1_o <= `SCB_RST_ZERO;
    end else if (ce_i) begin
      nvm_write_lock_o            <= !pump_en;
      addr_lock_o                 <= addr_locked;
      conn_check_en_o             <= cw[`SCB_CFG_DG_CONN];
      short_check_en_o            <= cw[`SCB_CFG_DG_SHORT];
      slave_addr_o                <= cw[`SCB_CFG_ADDR_MSB:`SCB_CFG_ADDR_LSB];
      bridge_offset_o             <= sh_reg[`SCB_IDX_BOFF];
      bridge_gain_o               <= scb_gain(sh_reg[`SCB_IDX_BGAIN]);
      gain_tc_o                   <= scb_signed(sh_reg[`SCB_IDX_TCG],
                                                sw[`SCB_SW_TC_GAIN]);
      offset_tc_o                 <= scb_signed(sh_reg[`SCB_IDX_TCO],
                                                sw[`SCB_SW_TC_OFF]);
      offset_tc_so_o              <= scb_signed(sh_reg[`SCB_IDX_SO_TCO],
                                                sw[`SCB_SW_SO_TCO]);
      gain_tc_so_o                <= scb_signed(sh_reg[`SCB_IDX_SO_TCG],
                                                sw[`SCB_SW_SO_TCG]);
      bridge_so_o                 <= scb_signed(sh_reg[`SCB_IDX_SO_BR],
                                                sw[`SCB_SW_SO_BR]);
      curve_shape_select_o        <= sw[`SCB_SW_CURVE];
      temp_offset_o               <= sh_reg[`SCB_IDX_TOFF];
      temp_gain_o                 <= scb_gain(sh_reg[`SCB_IDX_TGAIN]);
      temp_so_o                   <= scb_signed(sh_reg[`SCB_IDX_SO_T],
                                                sw[`SCB_SW_SO_T]);
      low_cal_raw_temperature_o   <= sh_reg[`SCB_IDX_TSETL];
      customer_identifier_word1_o <= sh_reg[`SCB_IDX_CUST1];
    end
  end

  assign cmd_busy_o       = busy_reg;
  assign rsp_valid_o      = rsp_valid_reg;
  assign rsp_data_o       = rsp_data_reg;
  assign diag_state_o     = diag_reg;
  assign addr_ack_valid_o = ack_valid_reg;
  assign addr_ack_o       = ack_reg;
  assign spi_miso_o       = miso_reg;

endmodule : scb_word_bank

// ===== tb/scb_word_bank_sva.sv
/*
  Port checker of the calibration word bank, attached by bind.
  Assumes ce_i is high whenever requests are made.
*/
`timescale 1ns/1ns
module scb_word_bank_chk (
  input wire logic       clk_sys_i, rst_i, ce_i, cmd_valid_i, cmd_write_i, cmd_busy_o,
  input wire logic       rsp_valid_o, enter_normal_operation_cmd_i, addr_valid_i,
  input wire logic       addr_ack_valid_o, addr_ack_o, addr_lock_o, nvm_write_lock_o,
  input wire logic       diag_state_o, conn_check_en_o, short_check_en_o,
  input wire logic [6:0] addr_i, slave_addr_o
);
  logic [11:0] cfg_vec;
  assign cfg_vec = {slave_addr_o, addr_lock_o, nvm_write_lock_o, diag_state_o,
                    conn_check_en_o, short_check_en_o};
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_read_answer: assert property (
    cmd_valid_i && !cmd_write_i && !cmd_busy_o && ce_i |=> rsp_valid_o)
    else $error("read not answered");
  a_read_cause: assert property (
    rsp_valid_o |-> $past(cmd_valid_i) && !$past(cmd_write_i) && !$past(cmd_busy_o))
    else $error("answer without read");
  a_ack_open: assert property (
    addr_valid_i && !cmd_busy_o && !addr_lock_o |=> addr_ack_valid_o && addr_ack_o)
    else $error("open bank did not ack");
  a_ack_locked: assert property (
    addr_valid_i && !cmd_busy_o && addr_lock_o |=>
      addr_ack_valid_o && (addr_ack_o == ($past(addr_i) == slave_addr_o)))
    else $error("locked ack wrong");
  a_ack_quiet: assert property (
    !addr_ack_valid_o |-> !addr_ack_o)
    else $error("ack outside pulse");
  a_cfg_frozen: assert property (
    !cmd_busy_o && !$past(cmd_busy_o) |-> $past(cfg_vec) === cfg_vec)
    else $error("config changed without reload");
  a_nom_busy: assert property (
    enter_normal_operation_cmd_i && !cmd_valid_i && !cmd_busy_o |=> cmd_busy_o)
    else $error("signing did not start");
  a_busy_bound: assert property (
    $rose(cmd_busy_o) |-> ##[1:40] !cmd_busy_o)
    else $error("busy too long");
endmodule : scb_word_bank_chk

bind scb_word_bank scb_word_bank_chk u_chk (.*);

// ===== tb/scb_spi_host.sv
/*
  Serial host model: reads one 16-bit word from the serial output.
  Assumes the caller sets pol_i before a frame.
*/
`timescale 1ns/1ns
module scb_spi_host (
  // Clock and mode
  input  wire logic clk_sys_i,
  input  wire logic pol_i,
  // Serial pins
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      ss_n_o
);
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
  end
  // Clock idles at update level, bit taken just before update edge
  task automatic frame(output logic [15:0] q);
    @(posedge clk_sys_i) sclk_o <= pol_i;
    repeat (5) @(posedge clk_sys_i);
    ss_n_o <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= !pol_i;
      repeat (5) @(posedge clk_sys_i);
      #1 q[i] = miso_i;
      @(posedge clk_sys_i) sclk_o <= pol_i;
      repeat (5) @(posedge clk_sys_i);
    end
    ss_n_o <= 1'b1;
  endtask : frame
endmodule : scb_spi_host

// ===== tb/scb_word_bank_tb_top.sv
/*
  Self-checking bench of the calibration word bank with a serial host.
  Assumes package, header and host model are compiled first.
*/
`timescale 1ns/1ns
module scb_word_bank_tb_top;
  import scb_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
  logic enter_normal_operation_cmd_i = 1'b0, factory_load_i = 1'b0, addr_valid_i = 1'b0;
  logic [7:0] cmd_word_i = 8'h00;
  logic [6:0] addr_i = 7'h00, slave_addr_o;
  scb_word_t cmd_wdata_i = 16'h0000, spi_data_i = 16'hA5C3, rsp_data_o, temp_offset_o;
  scb_word_t low_cal_raw_temperature_o, customer_identifier_word1_o;
  logic spi_sclk_i, spi_ss_n_i, cmd_busy_o, rsp_valid_o, addr_ack_valid_o, addr_ack_o;
  logic spi_miso_o, diag_state_o, nvm_write_lock_o, addr_lock_o, conn_check_en_o;
  logic short_check_en_o, curve_shape_select_o, pol = 1'b0;
  logic signed [15:0] bridge_offset_o;
  logic [17:0] bridge_gain_o, temp_gain_o;
  logic signed [16:0] gain_tc_o, offset_tc_o, offset_tc_so_o, gain_tc_so_o, bridge_so_o, temp_so_o;
  int err_count = 0, samples_checked = 0, cyc = 0;
  scb_word_bank uut (.*);
  scb_spi_host u_host (.clk_sys_i, .pol_i(pol), .miso_i(spi_miso_o), .sclk_o(spi_sclk_i),
    .ss_n_o(spi_ss_n_i));
  always #50 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report;
    end
  end
  task automatic chk(input logic [63:0] a, input logic [63:0] e);
    samples_checked++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic wb;
    repeat (60) begin
      @(posedge clk_sys_i) #1;
      if (cmd_busy_o === 1'b0) break;
    end
    chk(cmd_busy_o, 0);
  endtask : wb
  task automatic por;
    @(posedge clk_sys_i) rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wb;
  endtask : por
  task automatic pulse(input logic nom);
    @(posedge clk_sys_i) {enter_normal_operation_cmd_i, factory_load_i} <= {nom, !nom};
    @(posedge clk_sys_i) {enter_normal_operation_cmd_i, factory_load_i} <= 2'b00;
    wb;
  endtask : pulse
  task automatic wr(input logic [7:0] w, input scb_word_t d);
    @(posedge clk_sys_i) {cmd_valid_i, cmd_write_i, cmd_word_i, cmd_wdata_i} <= {2'b11, w, d};
    @(posedge clk_sys_i) cmd_valid_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] w, input scb_word_t e);
    @(posedge clk_sys_i) {cmd_valid_i, cmd_write_i, cmd_word_i} <= {2'b10, w};
    @(posedge clk_sys_i) cmd_valid_i <= 1'b0;
    #1;
    chk({rsp_valid_o, rsp_data_o}, {1'b1, e});
  endtask : rd
  task automatic ad(input logic [6:0] a, input logic e);
    @(posedge clk_sys_i) {addr_valid_i, addr_i} <= {1'b1, a};
    @(posedge clk_sys_i) addr_valid_i <= 1'b0;
    #1;
    chk({addr_ack_valid_o, addr_ack_o}, {1'b1, e});
  endtask : ad
  task automatic spi(input logic p);
    logic [15:0] q;
    pol = p;
    u_host.frame(q);
    chk(q, spi_data_i);
  endtask : spi
  ////////////////////////////////////////
  task automatic t_def;
    por;
    pulse(1'b0);
    por;
    chk({slave_addr_o, bridge_gain_o}, {7'h28, 18'h02000});
    chk({diag_state_o, conn_check_en_o, short_check_en_o}, 3'b000);
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h2000);
    rd(8'h0E, 16'h0000);
    rd(8'h0F, 16'h0000);
    @(posedge clk_sys_i) ce_i <= 1'b0;
    wr(8'h0D, 16'h7777);
    @(posedge clk_sys_i) ce_i <= 1'b1;
    rd(8'h0D, 16'h0000);
    ad(7'h12, 1'b1);
    spi(1'b0);
    $display("done t_def");
  endtask : t_def
  task automatic t_coef;
    logic [7:0] wi [13] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
    scb_word_t wv [13] = '{16'hFE49, 16'h8000, 16'h8001, 16'h0003, 16'h0005, 16'h0007,
      16'h0001, 16'h0002, 16'h1234, 16'h8002, 16'h0004, 16'hABCD, 16'h5A5A};
    foreach (wi[i]) wr(wi[i], wv[i]);
    foreach (wi[i]) rd(wi[i], wv[i]);
    chk({temp_offset_o, low_cal_raw_temperature_o, customer_identifier_word1_o},
        {16'h1234, 16'hABCD, 16'h5A5A});
    chk({bridge_offset_o}, 16'h8000);
    chk({bridge_gain_o, temp_gain_o}, {18'h8, 18'h10});
    chk({gain_tc_o, offset_tc_o}, {17'h1FFFD, 17'h1FFFB});
    chk({offset_tc_so_o, gain_tc_so_o}, {17'h1FFF9, 17'h1FFFF});
    chk({bridge_so_o, temp_so_o}, {17'h1FFFE, 17'h1FFFC});
    chk(curve_shape_select_o, 1);
    $display("done t_coef");
  endtask : t_coef
  task automatic t_cfg;
    wr(8'h02, 16'h0FFF);
    rd(8'h02, 16'h0FFF);
    chk(slave_addr_o, 7'h28);
    pulse(1'b1);
    por;
    chk({slave_addr_o, conn_check_en_o, short_check_en_o, addr_lock_o},
        10'h3FF);
    chk(diag_state_o, 0);
    ad(7'h7F, 1'b1);
    ad(7'h7E, 1'b0);
    spi(1'b1);
    $display("done t_cfg");
  endtask : t_cfg
  task automatic t_lock;
    wr(8'h02, 16'h6140);
    por;
    chk({diag_state_o, nvm_write_lock_o, addr_lock_o}, 3'b110);
    ad(7'h12, 1'b1);
    wr(8'h03, 16'h1111);
    rd(8'h03, 16'h8000);
    pulse(1'b1);
    por;
    chk(diag_state_o, 1);
    $display("done t_lock");
  endtask : t_lock
  initial begin
    t_def;
    t_coef;
    t_cfg;
    t_lock;
    final_report;
  end
endmodule : scb_word_bank_tb_top
